/* File: include/pdr_pkg.sv */
// Constants and types for the peripheral disable redirect block
package pdr_pkg;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam int NPER = 3;
  localparam logic [BUS_AW-1:0] ADC_OFFSET = 8'h80;
  localparam logic [7:0] ADC_RESET = 8'h00;
  // Writable bits; reserved 6-5 and 3 read zero
  localparam logic [7:0] ADC_RW_MASK = 8'h97;
  localparam int SP1_DIS_BIT = 0;
  localparam int SP2_DIS_BIT = 1;
  localparam int CLK_DIS_BIT = 2;
  localparam int GAP_TGT_BIT = 4;
  localparam int WPV_ENB_BIT = 7;
  // Peripheral index: 0 serial one, 1 serial two, 2 clock
  localparam int PER_SP1 = 0;
  localparam int PER_SP2 = 1;
  localparam int PER_CLK = 2;
  localparam logic [NPER-1:0][2:0] PER_DIS_BIT = {3'h2, 3'h1, 3'h0};
  // Legacy I/O placements, plain defaults
  localparam logic [NPER-1:0][15:0] PER_FIRST =
    {16'h0070, 16'h02f8, 16'h03f8};
  localparam logic [NPER-1:0][15:0] PER_LAST =
    {16'h0071, 16'h02ff, 16'h03ff};
  localparam logic [15:0] GAP_FIRST = 16'h0000;
  localparam logic [15:0] GAP_LAST = 16'h03ff;

  typedef struct packed {
    logic valid;
    logic memory_mapped_config_regs;
    logic write;
    logic [15:0] addr;
  } pdr_io_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [NPER-1:0] per;
    logic other;
    logic memory_mapped_config_regs;
    logic gp;
    logic gp_cs;
    logic pci;
  } pdr_route_t;

  typedef struct packed {
    logic [7:0] adc;
    logic bus_wait;
    logic [7:0] rdata;
    pdr_route_t route;
    logic [NPER-1:0] irq;
    logic [NPER-1:0] active;
  } pdr_state_t;

  localparam pdr_state_t PDR_ST_RESET = '{
    adc: ADC_RESET, bus_wait: 1'b1, active: 3'h7, default: '0};
endpackage : pdr_pkg

/* File: rtl/pdr_top.sv */
// Peripheral disable redirect: control register and I/O routing
//
// Functional notes
// R1: Clock disable clear keeps clock served internally
// R2: Clock disable set sends clock range externally
// R3: Clock interrupt stays wired to controller
// R4: Software clears clock interrupt enables first
// R5: Window chip select allowed in clock range
// R6: Serial two disable routes range externally
// R7: Serial two interrupt stays wired
// R8: Window chip select allowed, serial two range
// R9: Serial one disable routes range externally
// R10: Serial one interrupt stays wired
// R11: Window chip select allowed, serial one range
// R12: All three disable bits reset to zero
// R13: Software disables replaced units early at boot
// R14: Config register accesses always stay internal
// R15: Software avoids config regs of disabled ports
// R16: Gap target never diverts disabled units
// R17: Gap target steers unoccupied legacy addresses
// R18: Disabled unit never selected nor driving
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module pdr_top
  import pdr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BUS_DW-1:0] avs_writedata,
  input wire logic [BUS_DW/8-1:0] avs_byteenable,
  output logic [BUS_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pdr_io_req_t io_req,
  input wire logic win_gp_hit,
  input wire logic other_int_hit,
  input wire logic [NPER-1:0] irq_in,
  output pdr_route_t io_route,
  output logic [NPER-1:0] irq_to_ctrl,
  output logic [NPER-1:0] per_active,
  output logic wpv_irq_enable,
  output logic legacy_io_gap_target
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  pdr_state_t st_r;
  pdr_state_t st_nxt;
  logic [NPER-1:0] per_hit;
  logic [NPER-1:0] dis;
  logic bus_req;
  logic adc_sel;
  logic [7:0] adc_wr;

  // Async assert, release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Per-unit range decode and disable lookup
  generate
    for (genvar i = 0; i < NPER; i++) begin : g_per
      assign per_hit[i] = io_req.valid && !io_req.memory_mapped_config_regs &&
        (io_req.addr >= PER_FIRST[i]) &&
        (io_req.addr <= PER_LAST[i]);
      assign dis[i] = st_r.adc[PER_DIS_BIT[i]];
    end
  endgenerate

  assign bus_req = avs_read | avs_write;
  assign adc_sel = (avs_address == ADC_OFFSET);
  assign adc_wr = avs_writedata[7:0] & ADC_RW_MASK;

  always_comb begin
    st_nxt = st_r;
    // One wait cycle, then a single answer cycle
    st_nxt.bus_wait = !(bus_req && st_r.bus_wait);
    if (bus_req && st_r.bus_wait) begin
      st_nxt.rdata = adc_sel ? (st_r.adc & ADC_RW_MASK) : 8'h00;
    end
    // Write lands only on the answer edge
    if (avs_write && !st_r.bus_wait && adc_sel &&
        avs_byteenable[0]) begin
      st_nxt.adc = adc_wr;
    end
    for (int k = 0; k < NPER; k++) begin
      st_nxt.active[k] = !st_nxt.adc[PER_DIS_BIT[k]];
    end
    // Interrupt lines pass regardless of disables
    st_nxt.irq = irq_in; // see R3 R7 R10
    st_nxt.route = '0;
    st_nxt.route.valid = io_req.valid;
    st_nxt.route.write = io_req.write;
    if (io_req.valid) begin
      if (io_req.memory_mapped_config_regs) begin
        // Unit config registers are internal only
        st_nxt.route.memory_mapped_config_regs = 1'b1; // see R14
      end else if (|per_hit) begin
        st_nxt.route.per = per_hit & ~dis; // see R1 R18
        st_nxt.route.gp = |(per_hit & dis); // see R2 R6 R9 R16
        // A window may add a chip select here
        st_nxt.route.gp_cs = |(per_hit & dis) && win_gp_hit; // see R5 R8 R11
      end else if (other_int_hit) begin
        st_nxt.route.other = 1'b1;
      end else if (win_gp_hit) begin
        st_nxt.route.gp = 1'b1;
        st_nxt.route.gp_cs = 1'b1;
      end else if (io_req.addr >= GAP_FIRST &&
                   io_req.addr <= GAP_LAST) begin
        st_nxt.route.gp = !st_r.adc[GAP_TGT_BIT]; // see R17
        st_nxt.route.pci = st_r.adc[GAP_TGT_BIT]; // see R17
      end else begin
        st_nxt.route.pci = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= PDR_ST_RESET; // see R12
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = {24'h000000, st_r.rdata};
  assign avs_waitrequest = st_r.bus_wait;
  assign io_route = st_r.route;
  assign irq_to_ctrl = st_r.irq;
  assign per_active = st_r.active;
  assign wpv_irq_enable = st_r.adc[WPV_ENB_BIT];
  assign legacy_io_gap_target = st_r.adc[GAP_TGT_BIT];

  // Checks
  sequence s_unit_io(int i);
    io_req.valid && !io_req.memory_mapped_config_regs && per_hit[i];
  endsequence

  sequence s_kept(int i);
    io_route.per[i] && !io_route.gp && !io_route.pci;
  endsequence

  sequence s_sent_out(int i);
    io_route.gp && !io_route.per[i] && !io_route.pci;
  endsequence

  property p_internal(int i);
    @(posedge clk) disable iff (!rst_n)
      s_unit_io(i) ##0 !dis[i] |=> s_kept(i);
  endproperty

  property p_external(int i);
    @(posedge clk) disable iff (!rst_n)
      s_unit_io(i) ##0 dis[i] |=> s_sent_out(i);
  endproperty

  AST_CLK_INTERNAL: assert property (p_internal(PER_CLK)) // see R1
    else $error("Enabled clock access not served inside");
  AST_CLK_EXTERNAL: assert property (p_external(PER_CLK)) // see R2 R16
    else $error("Disabled clock access not on outer bus");
  AST_SP2_EXTERNAL: assert property (p_external(PER_SP2)) // see R6
    else $error("Disabled serial two access not on outer bus");
  AST_SP1_EXTERNAL: assert property (p_external(PER_SP1)) // see R9
    else $error("Disabled serial one access not on outer bus");
  AST_SP1_INTERNAL: assert property (p_internal(PER_SP1)) // see R9
    else $error("Enabled serial one access not served inside");
  AST_SP2_INTERNAL: assert property (p_internal(PER_SP2)) // see R6
    else $error("Enabled serial two access not served inside");

  AST_IRQ_PASS: assert property ( // see R3 R7 R10
    @(posedge clk) disable iff (!rst_n)
      ##1 irq_to_ctrl == $past(irq_in))
    else $error("Interrupt line not passed through");

  AST_WINDOW_CS: assert property ( // see R5 R8 R11
    @(posedge clk) disable iff (!rst_n)
      (|(per_hit & dis)) && win_gp_hit |=> io_route.gp_cs)
    else $error("Window chip select lost on disabled unit");

  AST_MEMORY_MAPPED_CONFIG_REGS_INSIDE: assert property ( // see R14
    @(posedge clk) disable iff (!rst_n)
      io_req.valid && io_req.memory_mapped_config_regs |=>
        io_route.memory_mapped_config_regs && !io_route.gp && !io_route.pci)
    else $error("Config access left the chip");

  AST_GAP_STEER: assert property ( // see R17
    @(posedge clk) disable iff (!rst_n)
      io_req.valid && !io_req.memory_mapped_config_regs && !(|per_hit) &&
      !other_int_hit && !win_gp_hit && io_req.addr <= GAP_LAST
      |=> io_route.pci == $past(st_r.adc[GAP_TGT_BIT]) &&
          io_route.gp == !$past(st_r.adc[GAP_TGT_BIT]))
    else $error("Gap access steered wrongly");

  AST_NO_DRIVE: assert property ( // see R18
    @(posedge clk) disable iff (!rst_n)
      (io_route.per & ~$past(st_r.active)) == 3'h0)
    else $error("Disabled unit selected");

  AST_RESET_CLEAR: assert property ( // see R12
    @(posedge clk) disable iff (!nrst)
      $rose(rst_n) |-> st_r.adc == ADC_RESET && per_active == 3'h7)
    else $error("Disable bits not clear after reset");

  AST_BUS_ANSWER: assert property (
    @(posedge clk) disable iff (!rst_n)
      bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not one cycle after request");

  AST_WRITE_LANDS: assert property (
    @(posedge clk) disable iff (!rst_n)
      avs_write && !avs_waitrequest && adc_sel && avs_byteenable[0]
      |=> st_r.adc == $past(adc_wr) &&
          per_active[PER_SP2] == !$past(avs_writedata[SP2_DIS_BIT]))
    else $error("Control write did not land");

  // Writes land only on the answer edge, never early
  AST_WRITE_WAITS: assert property (
    @(posedge clk) disable iff (!rst_n)
      avs_write && avs_waitrequest |=> $stable(st_r.adc))
    else $error("Control changed before the answer edge");

  AST_UNMAPPED_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
      avs_write && !avs_waitrequest && !(adc_sel && avs_byteenable[0])
      |=> $stable(st_r.adc))
    else $error("Ignored write changed the control bits");

  // Reserved bits can never be set, whatever software writes
  AST_RESERVED_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
      (st_r.adc & ~ADC_RW_MASK) == 8'h00)
    else $error("Reserved control bit set");

  // Answer data is the value before any write of the same access
  sequence s_reg_read;
    avs_read && avs_waitrequest && adc_sel;
  endsequence

  AST_READ_DATA: assert property (
    @(posedge clk) disable iff (!rst_n)
      s_reg_read |=> !avs_waitrequest &&
        avs_readdata == {24'h000000, $past(st_r.adc)})
    else $error("Control read returned wrong data");

  AST_UNMAPPED_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
      avs_read && avs_waitrequest && !adc_sel |=> avs_readdata == 32'h0)
    else $error("Unmapped read returned data");

  // Software may sample read data late, so it must not move
  AST_READ_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
      !(bus_req && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("Read data moved without an access");

  AST_WAIT_IDLE: assert property (
    @(posedge clk) disable iff (!rst_n)
      !bus_req && avs_waitrequest |=> avs_waitrequest)
    else $error("Answer given without a request");

  AST_ACTIVE_MIRROR: assert property ( // see R1 R6 R9
    @(posedge clk) disable iff (!rst_n)
      per_active == ~{st_r.adc[CLK_DIS_BIT], st_r.adc[SP2_DIS_BIT],
                      st_r.adc[SP1_DIS_BIT]})
    else $error("Unit enable outputs differ from disable bits");

  // Gap bit set must not pull a disabled unit onto the host bridge
  property p_gap_ignored(int i);
    @(posedge clk) disable iff (!rst_n)
      s_unit_io(i) ##0 (dis[i] && st_r.adc[GAP_TGT_BIT]) |=>
        io_route.gp && !io_route.pci;
  endproperty

  AST_CLK_GAP_IGNORED: assert property (p_gap_ignored(PER_CLK)) // see R16
    else $error("Disabled clock access sent to host bridge");
  AST_SP2_GAP_IGNORED: assert property (p_gap_ignored(PER_SP2)) // see R16
    else $error("Disabled serial two access sent to host bridge");
  AST_SP1_GAP_IGNORED: assert property (p_gap_ignored(PER_SP1)) // see R16
    else $error("Disabled serial one access sent to host bridge");

  AST_WINDOW_GAP: assert property ( // see R17
    @(posedge clk) disable iff (!rst_n)
      io_req.valid && !io_req.memory_mapped_config_regs && !(|per_hit) && !other_int_hit &&
      win_gp_hit |=> io_route.gp && io_route.gp_cs && !io_route.pci)
    else $error("Window access not on outer bus");

  // Each routed cycle has exactly one destination
  AST_ONE_DEST: assert property ( // see R14 R17 R18
    @(posedge clk) disable iff (!rst_n)
      io_route.valid |-> $onehot0(io_route.per) &&
        $onehot({|io_route.per, io_route.other, io_route.memory_mapped_config_regs,
                 io_route.gp, io_route.pci}))
    else $error("Routed cycle without a single destination");

  AST_ROUTE_IDLE: assert property ( // see R18
    @(posedge clk) disable iff (!rst_n)
      !io_req.valid |=> io_route == '0)
    else $error("Route shown without a request");

endmodule : pdr_top

/* File: verification/pdr_host_model.sv */
// Host CPU model issuing I/O and config-space cycles
`timescale 1ns/1ps
module pdr_host_model
  import pdr_pkg::*;
(
  input wire logic clk,
  output pdr_io_req_t io_req,
  output logic win_gp_hit,
  output logic other_int_hit
);
  initial begin
    io_req = '0;
    win_gp_hit = 1'b0;
    other_int_hit = 1'b0;
  end
  // One cycle per request; idle cycle after keeps the routes apart
  task automatic issue(input logic mm, input logic [15:0] a,
                       input logic win, input logic oth);
    @(posedge clk);
    io_req <= '{valid: 1'b1, memory_mapped_config_regs: mm, write: a[0], addr: a};
    win_gp_hit <= win;
    other_int_hit <= oth;
    @(posedge clk);
    io_req <= '0;
    win_gp_hit <= 1'b0;
    other_int_hit <= 1'b0;
  endtask : issue
endmodule : pdr_host_model

/* File: verification/tb_pdr_top.sv */
// Bench for the peripheral disable redirect block
`timescale 1ns/1ps
module tb_pdr_top
  import pdr_pkg::*;
;
  logic clk, nrst, rd, wr, win, oth;
  logic [7:0] addr, adc;
  logic [31:0] wd, rdata, q;
  logic [3:0] be;
  logic waitreq, gap, wpv;
  logic [2:0] irq_in, irq_out, act;
  pdr_io_req_t io_req;
  pdr_route_t route;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  pdr_top u_dut (.clk(clk), .nrst(nrst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .io_req(io_req),
    .win_gp_hit(win), .other_int_hit(oth), .irq_in(irq_in),
    .io_route(route), .irq_to_ctrl(irq_out), .per_active(act),
    .wpv_irq_enable(wpv), .legacy_io_gap_target(gap));
  pdr_host_model u_host (.clk(clk), .io_req(io_req),
    .win_gp_hit(win), .other_int_hit(oth));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk_val
  task automatic chk_route(input pdr_route_t got, input pdr_route_t exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk_route
  // Request held until waitrequest is sampled low at a rising edge
  task automatic av(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wd <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av
  function automatic pdr_route_t exp_route(logic mm, logic [15:0] a,
                                           logic w, logic o);
    pdr_route_t r;
    logic hit;
    r = '0;
    hit = 1'b0;
    r.valid = 1'b1;
    r.write = a[0];
    if (mm) return '{valid: 1'b1, write: a[0], memory_mapped_config_regs: 1'b1, default: '0};
    for (int i = 0; i < NPER; i++)
      if (a >= PER_FIRST[i] && a <= PER_LAST[i]) begin
        hit = 1'b1;
        if (adc[PER_DIS_BIT[i]]) {r.gp, r.gp_cs} = {1'b1, w};
        else r.per[i] = 1'b1;
      end
    if (hit) return r;
    if (o) r.other = 1'b1;
    else if (w) {r.gp, r.gp_cs} = 2'b11;
    else if (a <= GAP_LAST) {r.pci, r.gp} = {adc[4], !adc[4]};
    else r.pci = 1'b1;
    return r;
  endfunction : exp_route
  task automatic io(input logic mm, input logic [15:0] a,
                    input logic w, input logic o);
    u_host.issue(mm, a, w, o);
    #1;
    chk_route(route, exp_route(mm, a, w, o));
  endtask : io
  initial begin
    {nrst, rd, wr, addr, wd, be, irq_in} = '0;
    adc = 8'h00;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    av(1'b0, ADC_OFFSET, 32'h0, 4'hf);
    chk_val(q, 32'h0);
    chk_val(32'(act), 32'h7);
    av(1'b1, 8'h84, 32'hff, 4'hf);
    av(1'b0, 8'h84, 32'h0, 4'hf);
    chk_val(q, 32'h0);
    av(1'b1, ADC_OFFSET, 32'hff, 4'h0);
    av(1'b0, ADC_OFFSET, 32'h0, 4'hf);
    chk_val(q, 32'h0);
    // Disables set before traffic, as boot code would do
    for (int c = 0; c < 16; c++) begin
      adc = {c[0] ^ c[3], 2'h0, c[3], 1'b0, c[2:0]};
      av(1'b1, ADC_OFFSET, 32'(adc) | 32'h68, 4'h1);
      av(1'b0, ADC_OFFSET, 32'h0, 4'hf);
      chk_val(q, 32'(adc));
      chk_val(32'(gap), 32'(c[3]));
      chk_val(32'(wpv), 32'(adc[7]));
      chk_val(32'(act), {29'h0, ~c[2:0]});
      @(posedge clk);
      // Lines of disabled units stand for outside parts set up first
      irq_in <= c[2:0] ^ 3'h5;
      repeat (2) @(posedge clk);
      #1 chk_val(32'(irq_out), 32'(c[2:0] ^ 3'h5));
      for (int i = 0; i < NPER; i++) begin
        io(1'b0, PER_FIRST[i], c[0] ^ i[0], 1'b0);
        io(1'b0, PER_LAST[i], 1'b0, 1'b1);
        io(1'b1, PER_FIRST[i], 1'b0, 1'b0);
      end
      io(1'b0, 16'h0100, 1'b0, 1'b0);
      io(1'b0, 16'h0072, 1'b1, 1'b0);
      io(1'b0, 16'h0060, 1'b0, 1'b1);
      io(1'b0, 16'h0400, 1'b0, 1'b0);
    end
    give_verdict();
  end
endmodule : tb_pdr_top
